// *** lsi_pkg.sv ***
// Shared constants for the light result and threshold interrupt block
package lsi_pkg;
    // Register offsets
    localparam logic [7:0] LSI_CMD1_OFS = 8'h00;
    localparam logic [7:0] LSI_CMD2_OFS = 8'h01;
    localparam logic [7:0] LSI_RES_LO_OFS = 8'h02;
    localparam logic [7:0] LSI_RES_HI_OFS = 8'h03;
    localparam logic [7:0] LSI_LOW_LO_OFS = 8'h04;
    localparam logic [7:0] LSI_LOW_HI_OFS = 8'h05;
    localparam logic [7:0] LSI_UPP_LO_OFS = 8'h06;
    localparam logic [7:0] LSI_UPP_HI_OFS = 8'h07;
    localparam logic [7:0] LSI_TEST_OFS = 8'h08;
    // Field positions
    localparam int LSI_PRST_LSB = 0;
    localparam int LSI_FLAG_BIT = 2;
    localparam int LSI_OPMODE_LSB = 5;
    localparam int LSI_RANGE_LSB = 0;
    localparam int LSI_RES_LSB = 2;
    // Reset values
    localparam logic [7:0] LSI_RESULT_RST = 8'h00;
    localparam logic [7:0] LSI_LOWER_RST = 8'h00;
    localparam logic [7:0] LSI_UPPER_RST = 8'hFF;
    localparam logic [7:0] LSI_TEST_VAL = 8'h00;
    localparam logic [7:0] LSI_CMD_RST = 8'h00;
    // Fixed bus target address
    localparam logic [6:0] LSI_TARGET_ADDR = 7'h44;
    // Resolution codes and their bit counts
    localparam logic [1:0] LSI_RES_16 = 2'h0;
    localparam logic [1:0] LSI_RES_12 = 2'h1;
    localparam logic [1:0] LSI_RES_8 = 2'h2;
    localparam logic [1:0] LSI_RES_4 = 2'h3;
    localparam logic [4:0] LSI_BITS_16 = 5'h10;
    localparam logic [4:0] LSI_BITS_12 = 5'h0C;
    localparam logic [4:0] LSI_BITS_8 = 5'h08;
    localparam logic [4:0] LSI_BITS_4 = 5'h04;
    // Persistence counts
    localparam logic [4:0] LSI_PRST_N0 = 5'h01;
    localparam logic [4:0] LSI_PRST_N1 = 5'h04;
    localparam logic [4:0] LSI_PRST_N2 = 5'h08;
    localparam logic [4:0] LSI_PRST_N3 = 5'h10;

    // Serial slave states
    typedef enum logic [2:0] {
        LSI_IDLE = 3'b000,
        LSI_ADDR = 3'b001,
        LSI_ACK_ADDR = 3'b010,
        LSI_RX = 3'b011,
        LSI_ACK_RX = 3'b100,
        LSI_TX = 3'b101,
        LSI_ACK_TX = 3'b110
    } lsi_state_t;
endpackage

// *** lsi_reg_if.sv ***
// Byte access carrier between the serial slave and the register file
`timescale 1ns/1ps
interface lsi_reg_if;
    logic wr_stb;
    logic rd_done;
    logic frame;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport slave (output wr_stb, output rd_done, output frame, output addr, output wdata, input rdata);
    modport regs (input wr_stb, input rd_done, input frame, input addr, input wdata, output rdata);
endinterface

// *** lsi_i2c_slave.sv ***
// Serial two-wire target: address match, pointer, byte writes and reads
`timescale 1ns/1ps
module lsi_i2c_slave
    import lsi_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus pins
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Register side
    lsi_reg_if.slave rb
);
    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_d;
        logic sda_s1;
        logic sda_s2;
        logic sda_d;
        lsi_state_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic first;
        logic ack_on;
        logic [7:0] ptr;
        logic [7:0] wdata;
        logic oe;
        logic wr_stb;
        logic rd_done;
        logic frame;
    } lsi_slv_t;

    lsi_slv_t r, n;
    logic rise, fall, start, stop;
    logic [7:0] byte_in;

    ////////////////////////////////////////////////////////////////
    // Edge and condition detection on the second sync stage only
    assign rise = r.scl_s2 & ~r.scl_d;
    assign fall = ~r.scl_s2 & r.scl_d;
    assign start = r.scl_s2 & r.scl_d & r.sda_d & ~r.sda_s2;
    assign stop = r.scl_s2 & r.scl_d & ~r.sda_d & r.sda_s2;
    assign byte_in = {r.sh[6:0], r.sda_s2};

    // Next state of the target
    always_comb begin
        n = r;
        n.scl_s1 = scl;
        n.scl_s2 = r.scl_s1;
        n.scl_d = r.scl_s2;
        n.sda_s1 = sda_in;
        n.sda_s2 = r.sda_s1;
        n.sda_d = r.sda_s2;
        n.wr_stb = 1'b0;
        n.rd_done = 1'b0;
        n.frame = 1'b0;
        if (start) begin
            n.st = LSI_ADDR;
            n.cnt = 4'h0;
            n.first = 1'b1;
            n.oe = 1'b0;
            n.frame = 1'b1;
        end else if (stop) begin
            n.st = LSI_IDLE;
            n.oe = 1'b0;
            n.frame = 1'b1;
        end else if (rise) begin
            case (r.st)
                LSI_ADDR, LSI_RX: begin
                    n.sh = byte_in;
                    n.cnt = r.cnt + 4'h1;
                    if (r.cnt == 4'h7) begin
                        n.cnt = 4'h0;
                        if (r.st == LSI_ADDR) begin
                            // Hard-wired address, no strap
                            n.st = (r.sh[6:0] == LSI_TARGET_ADDR) ? LSI_ACK_ADDR : LSI_IDLE;
                            n.rw = r.sda_s2;
                        end else begin
                            n.st = LSI_ACK_RX;
                            if (r.first) begin
                                n.ptr = byte_in;
                                n.first = 1'b0;
                            end else begin
                                n.wdata = byte_in;
                                n.wr_stb = 1'b1;
                            end
                        end
                    end
                end
                LSI_TX: begin
                    n.cnt = r.cnt + 4'h1;
                    if (r.cnt == 4'h7) begin
                        n.cnt = 4'h0;
                        n.st = LSI_ACK_TX;
                        n.rd_done = 1'b1;
                    end
                end
                LSI_ACK_TX: begin
                    // Host NACK ends the read burst
                    n.ack_on = ~r.sda_s2;
                    if (r.sda_s2) begin
                        n.st = LSI_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end else if (fall) begin
            case (r.st)
                LSI_ACK_ADDR, LSI_ACK_RX: begin
                    if (!r.ack_on) begin
                        n.ack_on = 1'b1;
                        n.oe = 1'b1;
                    end else begin
                        n.ack_on = 1'b0;
                        n.oe = 1'b0;
                        n.st = LSI_RX;
                        if (r.st == LSI_ACK_ADDR && r.rw) begin
                            n.st = LSI_TX;
                            n.oe = ~rb.rdata[7];
                            n.sh = {rb.rdata[6:0], 1'b0};
                        end
                    end
                end
                LSI_TX: begin
                    if (r.cnt != 4'h0) begin
                        n.oe = ~r.sh[7];
                        n.sh = {r.sh[6:0], 1'b0};
                    end
                end
                LSI_ACK_TX: begin
                    if (r.ack_on) begin
                        n.ack_on = 1'b0;
                        n.st = LSI_TX;
                        n.oe = ~rb.rdata[7];
                        n.sh = {rb.rdata[6:0], 1'b0};
                    end else begin
                        n.oe = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // Pointer walks on after each data byte written or read
        if (r.wr_stb || r.rd_done) begin
            n.ptr = r.ptr + 8'h01;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r <= '{st: LSI_IDLE, scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
                   sda_d: 1'b1, default: '0};
        end else begin
            r <= n;
        end
    end

    // Open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = r.oe;
    assign rb.wr_stb = r.wr_stb;
    assign rb.rd_done = r.rd_done;
    assign rb.frame = r.frame;
    assign rb.addr = r.ptr;
    assign rb.wdata = r.wdata;
endmodule

// *** lsi_light_top.sv ***
// Light result registers, limit compare and persistent interrupt
//
// Contract
// - Result low byte at 0x02, high byte at 0x03, both read-only.
// - Valid result width follows resolution: 16, 12, 8 or 4 bits.
// - Result is right-aligned; bit zero always in low byte bit zero.
// - Both result bytes overwritten at the end of every conversion.
// - Result bytes read zero after reset until a conversion completes.
// - Result at or below lower limit raises interrupt pin and flag.
// - Lower limit is 16 bits, low byte 0x04, high byte 0x05.
// - Lower limit bytes reset to zero.
// - Result at or above upper limit raises interrupt pin and flag.
// - Upper limit is 16 bits, low byte 0x06, high byte 0x07.
// - Upper limit bytes reset to all ones.
// - Test register at 0x08 holds zero; host leaves it alone.
// - Integration lasts two to the n oscillator cycles, n from resolution.
// - Interrupt only after 1, 4, 8 or 16 consecutive out-of-window results.
// - Pin low and flag set until a read of register 0x00 completes.
// - Resolution code 00/01/10/11 selects 16/12/8/4 bits.
// - Fixed seven-bit bus address 1000100, not changeable.
`timescale 1ns/1ps
module lsi_light_top
    import lsi_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    // Two-wire bus
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    // Converter front end
    input wire logic OSC_CLK,
    input wire logic [15:0] ADC_RAW,
    // Interrupt
    output logic INT_N
);
    import lsi_pkg::*;

    typedef struct packed {
        logic [2:0] opmode;
        logic [1:0] prst;
        logic flag;
        logic [3:0] cmd2;
        logic [15:0] result;
        logic [15:0] lower;
        logic [15:0] upper;
        logic osc_s1;
        logic osc_s2;
        logic osc_d;
        logic [15:0] osc_cnt;
        logic [4:0] pcnt;
        logic int_n;
        logic conv_done;
        logic [7:0] snap;
        logic snap_v;
    } lsi_top_t;

    lsi_top_t r, n;
    lsi_reg_if rb ();
    logic osc_edge, outside, trig, rd_cmd1;
    logic [15:0] aligned;
    logic [1:0] res_sel;

    ////////////////////////////////////////////////////////////////
    // Helpers

    // Bits of result for a resolution code
    function automatic logic [4:0] lsi_bits(input logic [1:0] sel);
        logic [4:0] b;
        b = LSI_BITS_16;
        case (sel)
            LSI_RES_16: b = LSI_BITS_16;
            LSI_RES_12: b = LSI_BITS_12;
            LSI_RES_8: b = LSI_BITS_8;
            default: b = LSI_BITS_4;
        endcase
        return b;
    endfunction

    // Last oscillator count of an integration, two to the n minus one
    function automatic logic [15:0] lsi_last(input logic [1:0] sel);
        logic [16:0] span;
        span = 17'h00001 << lsi_bits(sel);
        return 16'(span - 17'h00001);
    endfunction

    // Required consecutive out-of-window count
    function automatic logic [4:0] lsi_need(input logic [1:0] sel);
        logic [4:0] k;
        k = LSI_PRST_N0;
        case (sel)
            2'h0: k = LSI_PRST_N0;
            2'h1: k = LSI_PRST_N1;
            2'h2: k = LSI_PRST_N2;
            default: k = LSI_PRST_N3;
        endcase
        return k;
    endfunction

    ////////////////////////////////////////////////////////////////
    // Serial target
    lsi_i2c_slave u_slave (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .scl(SCL),
        .sda_in(SDA_IN),
        .sda_out(SDA_OUT),
        .sda_oe(SDA_OE),
        .rb(rb.slave)
    );

    ////////////////////////////////////////////////////////////////
    // Conversion timing and compare terms
    assign res_sel = r.cmd2[LSI_RES_LSB +: 2];
    assign osc_edge = r.osc_s2 & ~r.osc_d;
    // Front end delivers full scale; keep the top n bits at the bottom
    assign aligned = ADC_RAW >> (5'h10 - lsi_bits(res_sel));
    // Compare against the value being stored, not the old one
    assign outside = (aligned <= r.lower) || (aligned >= r.upper);
    assign trig = r.conv_done && (r.pcnt >= lsi_need(r.prst));
    assign rd_cmd1 = rb.rd_done && (rb.addr == LSI_CMD1_OFS);

    ////////////////////////////////////////////////////////////////
    // Register read mux, if-chain decode
    always_comb begin
        rb.rdata = 8'h00;
        if (rb.addr == LSI_CMD1_OFS) begin
            rb.rdata = {r.opmode, 2'b00, r.flag, r.prst};
        end else if (rb.addr == LSI_CMD2_OFS) begin
            rb.rdata = {4'h0, r.cmd2};
        end else if (rb.addr == LSI_RES_LO_OFS) begin
            rb.rdata = r.result[7:0];
        end else if (rb.addr == LSI_RES_HI_OFS) begin
            rb.rdata = r.snap_v ? r.snap : r.result[15:8];
        end else if (rb.addr == LSI_LOW_LO_OFS) begin
            rb.rdata = r.lower[7:0];
        end else if (rb.addr == LSI_LOW_HI_OFS) begin
            rb.rdata = r.lower[15:8];
        end else if (rb.addr == LSI_UPP_LO_OFS) begin
            rb.rdata = r.upper[7:0];
        end else if (rb.addr == LSI_UPP_HI_OFS) begin
            rb.rdata = r.upper[15:8];
        end else if (rb.addr == LSI_TEST_OFS) begin
            rb.rdata = LSI_TEST_VAL;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        n = r;
        n.osc_s1 = OSC_CLK;
        n.osc_s2 = r.osc_s1;
        n.osc_d = r.osc_s2;
        n.conv_done = 1'b0;
        // Host writes; result and test registers ignore writes
        if (rb.wr_stb) begin
            if (rb.addr == LSI_CMD1_OFS) begin
                n.opmode = rb.wdata[LSI_OPMODE_LSB +: 3];
                n.prst = rb.wdata[LSI_PRST_LSB +: 2];
            end else if (rb.addr == LSI_CMD2_OFS) begin
                n.cmd2 = rb.wdata[3:0];
            end else if (rb.addr == LSI_LOW_LO_OFS) begin
                n.lower[7:0] = rb.wdata;
            end else if (rb.addr == LSI_LOW_HI_OFS) begin
                n.lower[15:8] = rb.wdata;
            end else if (rb.addr == LSI_UPP_LO_OFS) begin
                n.upper[7:0] = rb.wdata;
            end else if (rb.addr == LSI_UPP_HI_OFS) begin
                n.upper[15:8] = rb.wdata;
            end
        end
        // Low byte read freezes the high byte for the rest of the burst
        if (rb.rd_done && rb.addr == LSI_RES_LO_OFS) begin
            n.snap = r.result[15:8];
            n.snap_v = 1'b1;
        end
        if (rb.frame) begin
            n.snap_v = 1'b0;
        end
        // Integration counter; >= copes with a shrink in resolution mid-count
        if (osc_edge) begin
            if (r.osc_cnt >= lsi_last(res_sel)) begin
                n.osc_cnt = 16'h0000;
                n.conv_done = 1'b1;
                n.result = aligned;
                // Persistence count saturates at the largest setting
                if (outside) begin
                    n.pcnt = (r.pcnt == LSI_PRST_N3) ? r.pcnt : r.pcnt + 5'h01;
                end else begin
                    n.pcnt = 5'h00;
                end
            end else begin
                n.osc_cnt = r.osc_cnt + 16'h0001;
            end
        end
        // Clear by finished read of command one; a new trigger wins
        if (rd_cmd1) begin
            n.flag = 1'b0;
            n.int_n = 1'b1;
        end
        if (trig) begin
            n.flag = 1'b1;
            n.int_n = 1'b0;
        end
    end

    // State register, synchronous reset
    always_ff @(posedge SYS_CLK) begin
        if (!RESET_N) begin
            r <= '0;
            r.opmode <= LSI_CMD_RST[7:5];
            r.prst <= LSI_CMD_RST[1:0];
            r.cmd2 <= LSI_CMD_RST[3:0];
            r.result <= {LSI_RESULT_RST, LSI_RESULT_RST};
            r.lower <= {LSI_LOWER_RST, LSI_LOWER_RST};
            r.upper <= {LSI_UPPER_RST, LSI_UPPER_RST};
            r.int_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign INT_N = r.int_n;

    ////////////////////////////////////////////////////////////////
    // Checks
    a_int_tracks_flag: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        INT_N == !r.flag) else $error("interrupt pin and flag disagree");

    a_result_held: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        !r.conv_done |-> $stable(r.result) || $past(!RESET_N))
        else $error("result changed outside a conversion end");

    a_result_width: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        r.conv_done |-> (r.result >> lsi_bits($past(res_sel))) == 16'h0000)
        else $error("result wider than resolution");

    a_lower_trips: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (r.conv_done && r.result <= r.lower && r.prst == 2'h0) |=> r.flag)
        else $error("lower limit hit did not set flag");

    a_upper_trips: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (r.conv_done && r.result >= r.upper && r.prst == 2'h0) |=> !INT_N)
        else $error("upper limit hit did not drive pin");

    a_inside_quiet: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (!r.flag && !trig) |=> !r.flag) else $error("flag set without persistence met");

    a_flag_clear: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (rd_cmd1 && !trig) |=> (!r.flag && INT_N)) else $error("command read did not clear");

    a_persist_reset: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (osc_edge && r.osc_cnt >= lsi_last(res_sel) && !outside) |=> r.pcnt == 5'h00)
        else $error("persistence count not cleared on an inside result");

    a_reset_values: assert property (@(posedge SYS_CLK)
        $past(!RESET_N) && RESET_N |-> r.result == 16'h0000 && r.lower == 16'h0000 && r.upper == 16'hFFFF)
        else $error("bad reset values");

    a_conv_period: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        r.conv_done |-> r.osc_cnt == 16'h0000) else $error("counter not restarted at conversion end");
endmodule

// *** lsi_host_model.sv ***
// Two-wire bus host model that programs limits and reads results
`timescale 1ns/1ps
module lsi_host_model (
    // Bus pins
    output logic scl,
    output logic sda_line,
    input wire logic sda_oe
);
    logic drv_low = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Open-drain wire with pull-up; released line reads high, never stale
    assign sda_line = !(drv_low || sda_oe);
    initial scl = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // Quarter of the 64 ns bus clock; data bits move only while the clock is low
    task automatic qtr();
        #16;
    endtask

    // One bit: drive low phase, sample in the middle of the high phase
    task automatic bit_xfer(input logic b, output logic got);
        drv_low = !b;
        qtr();
        scl = 1'b1;
        qtr();
        got = sda_line;
        qtr();
        scl = 1'b0;
        qtr();
    endtask

    // Start or repeated start from either clock level
    task automatic start_cond();
        drv_low = 1'b0;
        qtr();
        scl = 1'b1;
        qtr();
        drv_low = 1'b1;
        qtr();
        scl = 1'b0;
        qtr();
    endtask

    // Stop: data rises while the clock is high
    task automatic stop_cond();
        drv_low = 1'b1;
        qtr();
        scl = 1'b1;
        qtr();
        drv_low = 1'b0;
        qtr();
    endtask

    // Byte out, most significant bit first, then the target's answer
    task automatic send(input logic [7:0] d, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], g);
        end
        bit_xfer(1'b1, g);
        ack = !g;
    endtask

    // Byte in; the last byte of a read is refused to end the burst
    task automatic recv(input logic last, output logic [7:0] d);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, g);
            d[i] = g;
        end
        bit_xfer(last, g);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Single register write; pointer and data only follow an answered address
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d, output logic ack);
        logic a;
        start_cond();
        send({dev, 1'b0}, ack);
        if (ack) begin
            send(ptr, a);
            send(d, a);
        end
        stop_cond();
    endtask

    // Burst read with repeated start; pointer advances per byte
    task automatic read_regs(input logic [6:0] dev, input logic [7:0] ptr, input int n, output logic [7:0] d [8]);
        logic a;
        start_cond();
        send({dev, 1'b0}, a);
        send(ptr, a);
        start_cond();
        send({dev, 1'b1}, a);
        for (int i = 0; i < n; i++) begin
            recv(i == n - 1, d[i]);
        end
        stop_cond();
    endtask
endmodule

// *** lsi_light_top_tb.sv ***
// Self-checking bench for the light result and threshold interrupt block
`timescale 1ns/1ps
module lsi_light_top_tb;
    import lsi_pkg::*;
    logic SYS_CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic OSC_CLK = 1'b0;
    logic [15:0] ADC_RAW = 16'h0000;
    logic scl, sda_line, sda_oe, INT_N, ack, SDA_OUT;
    logic [7:0] rb [8];
    logic [4:0] pn [4] = '{LSI_PRST_N0, LSI_PRST_N1, LSI_PRST_N2, LSI_PRST_N3};
    int fail_count = 0;
    int n_tests = 0;
    int osc_n = 0;
    int s, e, cnt, nb;
    logic [15:0] v;

    ////////////////////////////////////////////////////////////////////////
    // Clocks; oscillator edges fall on the falling system clock edge
    always #2.5 SYS_CLK = ~SYS_CLK;
    always #5 OSC_CLK = ~OSC_CLK;
    always @(posedge OSC_CLK) osc_n++;

    lsi_light_top u_dut (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .SCL(scl), .SDA_IN(sda_line), .SDA_OUT(SDA_OUT),
        .SDA_OE(sda_oe), .OSC_CLK(OSC_CLK), .ADC_RAW(ADC_RAW), .INT_N(INT_N));
    lsi_host_model u_host (.scl(scl), .sda_line(sda_line), .sda_oe(sda_oe));

    ////////////////////////////////////////////////////////////////////////
    // Comparison, bus and wait helpers
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        u_host.write_reg(LSI_TARGET_ADDR, ptr, d, ack);
        check("address ack", 16'(ack), 16'h0001);
    endtask

    task automatic rd(input logic [7:0] ptr, input int n);
        u_host.read_regs(LSI_TARGET_ADDR, ptr, n, rb);
    endtask

    task automatic set_adc(input logic [15:0] val);
        @(negedge SYS_CLK);
        ADC_RAW = val;
    endtask

    // Oscillator-edge wait; conversion ends are tied to these edges
    task automatic wait_osc(input int n);
        s = osc_n;
        while (osc_n < s + n) @(negedge SYS_CLK);
    endtask

    // Bounded wait for the interrupt pin, edges counted since s
    task automatic wait_int();
        cnt = 0;
        while (INT_N !== 1'b0 && cnt < 10000) begin
            @(negedge SYS_CLK);
            cnt++;
        end
        e = osc_n - s;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog well beyond the expected run of about 270 us, inside the cycle budget
    initial begin
        #450000;
        fail_count++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (16) @(negedge SYS_CLK);
        RESET_N = 1'b1;
        repeat (4) @(negedge SYS_CLK);
        // Wrong address must go unanswered; read-only places ignore writes
        u_host.write_reg(7'h45, LSI_LOW_LO_OFS, 8'h55, ack);
        check("foreign address", 16'(ack), 16'h0000);
        wr(LSI_RES_LO_OFS, 8'h5A);
        wr(LSI_RES_HI_OFS, 8'hA5);
        wr(LSI_TEST_OFS, 8'h00);
        check("data pin level", 16'(SDA_OUT), 16'h0000);
        rd(LSI_RES_LO_OFS, 7);
        for (int i = 0; i < 7; i++) begin
            check("reset value", 16'(rb[i]), (i == 4 || i == 5) ? 16'(LSI_UPPER_RST) : 16'h0000);
        end
        $display("test reset values done");

        // Right-aligned result at 4, 8 and 12 bits
        for (int c = 3; c >= 1; c--) begin
            nb = 16 - 4 * c;
            v = 16'hA5C3 + 16'(c);
            set_adc(v);
            wr(LSI_CMD2_OFS, {4'h0, 2'(c), 2'(c)});
            wait_osc((2 << nb) + 8);
            rd(LSI_RES_LO_OFS, 2);
            check("result", {rb[1], rb[0]}, v >> (16 - nb));
        end
        $display("test resolution done");

        // Limits: upper 0x0180 needs its high byte to keep 0xC0 inside
        wr(LSI_LOW_LO_OFS, 8'h10);
        wr(LSI_LOW_HI_OFS, 8'h00);
        wr(LSI_UPP_LO_OFS, 8'h80);
        wr(LSI_UPP_HI_OFS, 8'h01);
        rd(LSI_CMD2_OFS, 7);
        check("command two", 16'(rb[0]), 16'h0005);
        check("result hold", {rb[2], rb[1]}, v >> 4);
        check("lower limit", {rb[4], rb[3]}, 16'h0010);
        check("upper limit", {rb[6], rb[5]}, 16'h0180);
        wr(LSI_CMD2_OFS, {4'h0, LSI_RES_8, 2'h0});

        // Persistence per code, lower side trips, flag holds until read
        for (int c = 0; c < 4; c++) begin
            wr(LSI_CMD1_OFS, {3'h5, 3'h0, 2'(c)});
            set_adc(16'hC000);
            wait_osc(2 * 256 + 8);
            rd(LSI_CMD1_OFS, 1);
            check("int cleared", 16'(INT_N), 16'h0001);
            set_adc(16'h0800);
            s = osc_n;
            wait_int();
            check("persist span", 16'(e >= (int'(pn[c]) - 1) * 256 - 4 && e <= int'(pn[c]) * 256 + 4), 16'h0001);
            set_adc(16'hC000);
            wait_osc(2 * 256 + 8);
            check("int held", 16'(INT_N), 16'h0000);
            rd(LSI_CMD1_OFS, 1);
            check("flag", 16'(rb[0]), 16'(8'hA4 | 8'(c)));
            check("int after read", 16'(INT_N), 16'h0001);
        end
        $display("test persistence done");

        // Upper side trips once the limit drops to 0x0080
        wr(LSI_CMD1_OFS, 8'h00);
        wr(LSI_UPP_HI_OFS, 8'h00);
        s = osc_n;
        wait_int();
        check("upper trip", 16'(INT_N), 16'h0000);
        check("upper span", 16'(e <= 256 + 4), 16'h0001);
        $display("test upper limit done");
        tally_and_finish();
    end
endmodule
